//--- ecd_pkg.sv
// constants shared by the encoder direction and zero-preset control
package ecd_pkg;
    // position code width
    localparam int unsigned POS_W        = 25;
    // preset value after manufacture
    localparam logic [24:0] PRESET_RESET = 25'h0000000;
    // clock rate
    localparam int unsigned CLK_HZ       = 100_000_000;
    // least high time of the zero input, in ms
    localparam int unsigned ZERO_MIN_MS  = 10;
    // least high time in cycles, rounded down
    localparam int unsigned ZERO_MIN_CYC =
        (CLK_HZ / 1000 * ZERO_MIN_MS + 0);
    // position refresh rate per second
    localparam int unsigned UPDATE_HZ    = 1600;
    // refresh period in cycles, rounded down
    localparam int unsigned UPDATE_CYC   = CLK_HZ / UPDATE_HZ;
    // qualifier counter width, holds ZERO_MIN_CYC
    localparam int unsigned QCNT_W       = 21;
    // refresh counter width, holds UPDATE_CYC
    localparam int unsigned UCNT_W       = 17;
    // cycles after reset until the synchroniser holds the pin level
    localparam logic [1:0]  DIR_SETTLE   = 2'h3;
endpackage

//--- ecd_pin_if.sv
// synchronised pin level and one-cycle qualified event
`timescale 1ns/1ps
`default_nettype none
interface ecd_pin_if;
    logic level;   // synchronised pin level
    logic fire;    // one pulse once the level stood long enough
    modport src (output level, output fire);
    modport dst (input level, input fire);
endinterface
`default_nettype wire

//--- ecd_pin_qual.sv
// two-stage synchroniser with high-time qualifier for one input pin
`timescale 1ns/1ps
`default_nettype none
module ecd_pin_qual #(
    parameter int unsigned QUAL_CYC = 1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // raw pin
    input  wire logic pin_raw,
    // qualified result
    ecd_pin_if.src    q
);
    localparam logic [ecd_pkg::QCNT_W-1:0] QUAL_LAST =
        ecd_pkg::QCNT_W'(QUAL_CYC - 1);

    logic                      sync_a;    // first stage, read by sync_b only
    logic                      sync_b;    // second stage
    logic [ecd_pkg::QCNT_W-1:0] cnt;      // cycles the level stood high
    logic                      done;      // event already given this pulse
    logic                      fire;
    logic [ecd_pkg::QCNT_W-1:0] next_cnt;
    logic                      next_done;
    logic                      next_fire;

    // qualifier: count high cycles, fire once per pulse
    always_comb begin
        next_cnt  = cnt;
        next_done = done;
        next_fire = 1'b0;
        if (!sync_b) begin
            // low level rearms the qualifier
            next_cnt  = '0;
            next_done = 1'b0;
        end else if (!done) begin
            if (cnt == QUAL_LAST) begin
                next_fire = 1'b1;
                next_done = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            cnt    <= '0;
            done   <= 1'b0;
            fire   <= 1'b0;
        end else begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
            cnt    <= next_cnt;
            done   <= next_done;
            fire   <= next_fire;
        end
    end

    assign q.level = sync_b;
    assign q.fire  = fire;

    // event only after a high level
    a_fire_needs_high: assert property (@(posedge clk) disable iff (reset)
        fire |-> $past(sync_b)) else $error("qualified event without high");
    // one event per pulse
    a_fire_once: assert property (@(posedge clk) disable iff (reset)
        fire |=> !fire until_with !sync_b)
        else $error("second event within one pulse");
endmodule
`default_nettype wire

//--- ecd_ctrl.sv
// direction select, zero preset and position refresh of the encoder
`timescale 1ns/1ps
`default_nettype none
module ecd_ctrl #(
    parameter int unsigned ZERO_CYC   = ecd_pkg::ZERO_MIN_CYC,
    parameter int unsigned UPDATE_CYC = ecd_pkg::UPDATE_CYC
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // external pins
    input  wire logic                    dir_pin,
    input  wire logic                    zero_pin,
    // stored settings
    input  wire logic                    dir_setting_ccw,
    input  wire logic [ecd_pkg::POS_W-1:0] preset_value,
    // shaft steps from the sensor, same clock
    input  wire logic                    step_valid,
    input  wire logic                    step_cw,
    // position output
    output logic [ecd_pkg::POS_W-1:0]    position,
    output logic                         position_valid,
    output logic                         count_up_cw,
    output logic                         preset_busy
);
    localparam logic [ecd_pkg::UCNT_W-1:0] UPD_LAST =
        ecd_pkg::UCNT_W'(UPDATE_CYC - 1);

    ecd_pin_if dir_q ();
    ecd_pin_if zero_q ();

    // direction pin: synchronised only
    ecd_pin_qual #(.QUAL_CYC(1)) u_dir (
        .clk     (clk),
        .reset   (reset),
        .pin_raw (dir_pin),
        .q       (dir_q)
    );

    // zero input: synchronised and qualified over the least high time
    ecd_pin_qual #(.QUAL_CYC(ZERO_CYC)) u_zero (
        .clk     (clk),
        .reset   (reset),
        .pin_raw (zero_pin),
        .q       (zero_q)
    );

    logic [1:0]                settle;      // startup wait for the pin
    logic                      dir_ready;   // pin level captured
    logic                      dir_ccw;     // captured pin level
    logic [ecd_pkg::POS_W-1:0] pos;         // live position
    logic [ecd_pkg::UCNT_W-1:0] ucnt;       // refresh divider
    logic [1:0]                next_settle;
    logic                      next_dir_ready;
    logic                      next_dir_ccw;
    logic [ecd_pkg::POS_W-1:0] next_pos;
    logic [ecd_pkg::UCNT_W-1:0] next_ucnt;
    logic [ecd_pkg::POS_W-1:0] next_position;
    logic                      next_valid;
    logic                      next_up_cw;
    logic                      next_busy;
    logic                      tick;

    // power-up capture of the direction pin
    always_comb begin
        next_settle    = settle;
        next_dir_ready = dir_ready;
        next_dir_ccw   = dir_ccw;
        if (!dir_ready) begin
            if (settle == ecd_pkg::DIR_SETTLE) begin
                next_dir_ready = 1'b1;
                next_dir_ccw   = dir_q.level;
            end else begin
                next_settle = settle + 2'h1;
            end
        end
    end

    // position counting, preset load and refresh
    always_comb begin
        tick          = (ucnt == UPD_LAST);
        next_ucnt     = tick ? '0 : ucnt + 1'b1;
        // clockwise counts up only for low pin and clockwise setting
        next_up_cw    = !dir_ccw && !dir_setting_ccw;
        next_pos      = pos;
        if (zero_q.fire) begin
            // preset replaces position, shaft assumed at rest
            next_pos = preset_value;
        end else if (step_valid && dir_ready) begin
            if (step_cw == count_up_cw) begin
                next_pos = pos + 1'b1;
            end else begin
                next_pos = pos - 1'b1;
            end
        end
        next_position = tick ? pos : position;
        next_busy     = zero_q.level;
        // invalid while the zero pulse stands, valid from next refresh
        if (zero_q.level) begin
            next_valid = 1'b0;
        end else if (tick && dir_ready) begin
            next_valid = 1'b1;
        end else begin
            next_valid = position_valid;
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (reset) begin
            settle         <= 2'h0;
            dir_ready      <= 1'b0;
            dir_ccw        <= 1'b0;
            pos            <= ecd_pkg::PRESET_RESET;
            ucnt           <= '0;
            position       <= ecd_pkg::PRESET_RESET;
            position_valid <= 1'b0;
            count_up_cw    <= 1'b0;
            preset_busy    <= 1'b0;
        end else begin
            settle         <= next_settle;
            dir_ready      <= next_dir_ready;
            dir_ccw        <= next_dir_ccw;
            pos            <= next_pos;
            ucnt           <= next_ucnt;
            position       <= next_position;
            position_valid <= next_valid;
            count_up_cw    <= next_up_cw;
            preset_busy    <= next_busy;
        end
    end

    // sense follows the table of pin and setting
    a_dir_sense: assert property (@(posedge clk) disable iff (reset)
        dir_ready |=> count_up_cw == (!$past(dir_ccw)
                                      && !$past(dir_setting_ccw)))
        else $error("count direction mismatch");
    // captured level never changes after power-up
    a_dir_frozen: assert property (@(posedge clk) disable iff (reset)
        dir_ready |=> dir_ready && $stable(dir_ccw))
        else $error("direction level changed after capture");
    // qualified zero event loads the preset
    a_preset_load: assert property (@(posedge clk) disable iff (reset)
        zero_q.fire |=> pos == $past(preset_value))
        else $error("preset not loaded");
    // output takes the live position once per refresh period
    sequence s_refresh;
        tick ##1 (position == $past(pos));
    endsequence
    a_refresh_take: assert property (@(posedge clk) disable iff (reset)
        tick |-> s_refresh) else $error("refresh missed");
    a_refresh_gap: assert property (@(posedge clk) disable iff (reset)
        tick |=> !tick [*8]) else $error("refresh too often");
    // position output stands between refresh ticks
    a_pos_stands: assert property (@(posedge clk) disable iff (reset)
        !tick |=> $stable(position)) else $error("position changed early");

    // helper state for the refresh watchdog, not part of the function
    logic [ecd_pkg::UCNT_W-1:0] since_tick; // cycles since the last tick
    logic [ecd_pkg::UCNT_W-1:0] next_since; // next value of the count

    // helper: restart on every tick, count up otherwise
    always_comb begin
        if (tick) begin
            next_since = '0;
        end else begin
            next_since = since_tick + 1'b1;
        end
    end

    // helper register
    always_ff @(posedge clk) begin
        if (reset) begin
            since_tick <= '0;
        end else begin
            since_tick <= next_since;
        end
    end

    // ticks are never further apart than one refresh period
    a_refresh_due: assert property (@(posedge clk) disable iff (reset)
        since_tick <= UPD_LAST) else $error("refresh overdue");
    // no valid position while the zero pulse stands
    a_busy_invalid: assert property (@(posedge clk) disable iff (reset)
        zero_q.level |=> !position_valid && preset_busy)
        else $error("valid position during zero pulse");

    // busy follows the synchronised zero level down again
    a_busy_clear: assert property (@(posedge clk) disable iff (reset)
        !zero_q.level |=> !preset_busy) else $error("busy stuck after pulse");

    // valid returns only on a tick with the zero pulse gone
    a_valid_rise: assert property (@(posedge clk) disable iff (reset)
        $rose(position_valid) |-> $past(tick) && !$past(zero_q.level))
        else $error("valid rose outside a refresh");

    // the captured level is the synchronised pin level
    a_dir_capture: assert property (@(posedge clk) disable iff (reset)
        $rose(dir_ready) |-> dir_ccw == $past(dir_q.level))
        else $error("direction level not captured");

    // steps before the direction capture leave the position alone
    a_early_steps: assert property (@(posedge clk) disable iff (reset)
        !dir_ready && !zero_q.fire |=> $stable(pos))
        else $error("position moved before capture");

    // an accepted step one way or the other
    sequence s_step_up;
        step_valid && dir_ready && !zero_q.fire && step_cw == count_up_cw;
    endsequence
    sequence s_step_down;
        step_valid && dir_ready && !zero_q.fire && step_cw != count_up_cw;
    endsequence

    // an accepted step moves the live position by one
    a_step_up: assert property (@(posedge clk) disable iff (reset)
        s_step_up |=> pos == $past(pos) + 1'b1)
        else $error("step up not counted");
    a_step_down: assert property (@(posedge clk) disable iff (reset)
        s_step_down |=> pos == $past(pos) - 1'b1)
        else $error("step down not counted");
endmodule
`default_nettype wire

//--- ecd_reader_model.sv
// position-reading controller model on the far side of the encoder
`timescale 1ns/1ps
`default_nettype none
module ecd_reader_model (
    // clock
    input  wire logic        clk,
    // position offered by the encoder
    input  wire logic [24:0] position,
    input  wire logic        position_valid,
    // zero-preset pin driven by the controller
    output logic             zero_pin
);
    logic [24:0] last_read; // last position taken while valid
    initial zero_pin = 1'b0;
    // level change of the zero pin, made for both the short and the long pulse of the bench
    task automatic set_zero(input logic v);
        zero_pin = v;
    endtask
    // take a reading only while the encoder offers valid values
    always @(posedge clk) begin
        if (position_valid === 1'b1 && zero_pin === 1'b0) begin
            last_read <= position;
        end
    end
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the encoder direction and zero-preset control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned ZC = 20; // shortened zero qualification
    localparam int unsigned UC = 16; // shortened refresh period
    logic        clk, reset, dir_pin, dir_setting_ccw;
    logic        step_valid, step_cw, zero_pin;
    logic        position_valid, count_up_cw, preset_busy;
    logic [24:0] preset_value, position, base;
    int          errors, cmp_count, t0, t1;
    ecd_ctrl #(.ZERO_CYC(ZC), .UPDATE_CYC(UC)) DUT (
        .clk(clk), .reset(reset), .dir_pin(dir_pin), .zero_pin(zero_pin),
        .dir_setting_ccw(dir_setting_ccw), .preset_value(preset_value),
        .step_valid(step_valid), .step_cw(step_cw), .position(position),
        .position_valid(position_valid), .count_up_cw(count_up_cw),
        .preset_busy(preset_busy));
    ecd_reader_model P (.clk(clk), .position(position),
        .position_valid(position_valid), .zero_pin(zero_pin));
    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // compare and count
    task automatic check(input logic [24:0] got, input logic [24:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait for valid position, then two full refresh periods
    task automatic wait_valid();
        int i;
        for (i = 0; i < 200 && position_valid !== 1'b1; i++) cyc(1);
        if (position_valid !== 1'b1) begin
            errors++;
            wrap_up();
        end
        cyc(2 * UC);
    endtask
    // back-to-back shaft steps
    task automatic steps(input int n, input logic cw);
        repeat (n) begin
            step_valid = 1'b1;
            step_cw = cw;
            cyc(1);
        end
        step_valid = 1'b0;
        cyc(1);
    endtask
    // pin level set before power-up, changed afterwards
    task automatic test_dir(input logic p, input logic s);
        dir_pin = p;
        dir_setting_ccw = s;
        reset = 1'b1;
        cyc(6);
        reset = 1'b0;
        steps(1, 1'b1);
        cyc(7);
        dir_pin = ~p;
        wait_valid();
        check({24'h0, count_up_cw}, {24'h0, ~p & ~s});
        steps(5, ~p & ~s);
        steps(2, p | s);
        cyc(2 * UC + 2);
        check(P.last_read, 25'h0000003);
        $display("direction test done pin %0d setting %0d", p, s);
    endtask
    // short pulse ignored, long pulse loads preset once
    task automatic test_zero();
        base = P.last_read;
        P.set_zero(1'b1);
        cyc(8);
        P.set_zero(1'b0);
        cyc(2 * UC + 4);
        check(P.last_read, base);
        preset_value = 25'h1FFFFFF;
        // shaft held still for the whole pulse
        P.set_zero(1'b1);
        cyc(5);
        check({23'h0, preset_busy, position_valid}, 25'h2);
        cyc(ZC + 10);
        check({24'h0, position_valid}, 25'h0);
        P.set_zero(1'b0);
        wait_valid();
        check(P.last_read, 25'h1FFFFFF);
        // counting resumes from the preset and wraps at the range end
        steps(3, count_up_cw);
        cyc(2 * UC + 2);
        check(P.last_read, 25'h0000002);
        $display("zero preset test done");
    endtask
    // continuous stepping shows the refresh spacing
    task automatic test_rate();
        int i;
        t0 = -1;
        t1 = -1;
        base = position;
        step_cw = count_up_cw;
        step_valid = 1'b1;
        for (i = 0; i < 4 * UC; i++) begin
            cyc(1);
            if (position !== base && t0 < 0) t0 = i;
            else if (position !== base && t1 < 0) t1 = i;
            base = position;
        end
        step_valid = 1'b0;
        check(25'(t1 - t0), 25'(UC));
        $display("refresh rate test done");
    endtask
    // main sequence
    initial begin
        errors = 0;
        cmp_count = 0;
        reset = 1'b1;
        dir_pin = 1'b0;
        dir_setting_ccw = 1'b0;
        step_valid = 1'b0;
        step_cw = 1'b0;
        preset_value = 25'h0000000;
        cyc(6);
        test_dir(1'b0, 1'b0);
        test_dir(1'b1, 1'b0);
        test_dir(1'b0, 1'b1);
        test_dir(1'b1, 1'b1);
        test_zero();
        test_rate();
        wrap_up();
    end
endmodule
`default_nettype wire
